// File: rtl/scl_defs.svh
// Purpose: constants for the serial card logger front end
// Assumes: 200 MHz core clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH
`define SCL_CLK_HZ 200000000
`define SCL_HEARTBEAT_MS 1000
`define SCL_HEARTBEAT_CYC ((`SCL_CLK_HZ / 1000) * `SCL_HEARTBEAT_MS)
`define SCL_CYC_PER_MS (`SCL_CLK_HZ / 1000)
`define SCL_FLUSH_MAX 4095
`define SCL_DEFAULT_BAUD 9600
`define SCL_FRAME_BITS 8
`define SCL_IDX_W 16
`define SCL_RATE_SEL_W 3
`define SCL_RATE_DEFAULT 3'h3
`endif

// File: rtl/scl_pkg.sv
// Purpose: types for the serial card logger front end
// Assumes: nothing
// Notes: mode and serial engine states
package scl_pkg;
	typedef enum logic {SCL_MODE_NORMAL, SCL_MODE_AUTO} scl_mode_t;
	typedef enum logic [1:0] {SCL_RX_IDLE, SCL_RX_START, SCL_RX_DATA, SCL_RX_STOP} scl_rx_state_t;
	typedef enum logic [1:0] {SCL_TX_IDLE, SCL_TX_START, SCL_TX_DATA, SCL_TX_STOP} scl_tx_state_t;
endpackage : scl_pkg

// File: rtl/scl_logger_io.sv
// Purpose: serial capture front end: receive bytes, frame them for storage, heartbeat out
// Assumes: storage side accepts a byte with valid/ready; pull-ups are in the pad ring
// Notes: pins pass a three-stage synchroniser; straps sampled after reset
// Overview of operation
// - each received byte passed on unchanged, in arrival order, unless the next arrives before storage takes it
// - 115200 baud sustained; byte path never drops while storage ready
// - append, command split, and size-limit split storage patterns
// - split input active low; in auto mode each assertion bumps file index
// - outside auto mode the split input is ignored
// - reset input active low returns module to initial state except file index and strap mode; idles high
// - in auto mode each reset assertion also bumps file index
// - heartbeat byte about once a second, incrementing, wrapping 0 to 255
// - straps shorted: receive only from the RS232 line
// - straps open: receive from LVTTL line; heartbeat on matching output
// - frame is eight data bits, no parity, one stop bit
// - eight listed rates; any other setting falls back to 9600
// - commit at byte count (max 4095) or after idle time in ms
`timescale 1ns/10ps
`include "scl_defs.svh"
module scl_logger_io #(
	parameter int unsigned CLK_HZ = `SCL_CLK_HZ,
	parameter int unsigned HEARTBEAT_CYC = `SCL_HEARTBEAT_CYC,
	parameter int unsigned CYC_PER_MS = `SCL_CYC_PER_MS,
	parameter int unsigned IDX_W = `SCL_IDX_W
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_rx_lvttl,
	input wire logic i_rx_rs232,
	input wire logic i_file_split_n,
	input wire logic i_module_reset_n,
	input wire logic i_level_select_strap_a,
	input wire logic i_level_select_strap_b,
	input wire scl_pkg::scl_mode_t i_operating_mode_setting,
	input wire logic [2:0] i_line_rate_setting,
	input wire logic [11:0] i_flush_byte_count,
	input wire logic [15:0] i_idle_flush_ms,
	input wire logic [31:0] i_file_max_len,
	input wire logic i_store_ready,
	output logic o_tx_lvttl,
	output logic o_tx_rs232,
	output logic [7:0] o_store_data,
	output logic o_store_valid,
	output logic o_commit,
	output logic [IDX_W-1:0] o_file_index,
	output logic o_file_new,
	output logic o_rs232_mode,
	output logic o_overrun
);
	import scl_pkg::*;

	initial begin
		if (CLK_HZ < 2000000 || HEARTBEAT_CYC < 1 || CYC_PER_MS < 1 || IDX_W < 1)
			$error("scl_logger_io: unsupported parameters");
	end

	// pin synchronisers: stage 1 read only by stage 2
	logic [4:0] s1_q, s2_q, s3_q;
	wire logic [4:0] pins = {i_rx_lvttl, i_rx_rs232, i_file_split_n, i_module_reset_n,
		~(i_level_select_strap_a | i_level_select_strap_b)};
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_q <= 5'h1f;
			s2_q <= 5'h1f;
			s3_q <= 5'h1f;
		end else if (i_clk_en) begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// a level counts once stages two and three agree
	logic [4:0] lvl_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n)
			lvl_q <= 5'h1f;
		else if (i_clk_en)
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
	end

	// strap caught once the synchroniser has settled; shorted straps read both low
	logic rs232_q, strap_done_q;
	logic [2:0] strap_wait_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rs232_q <= 1'b0;
			strap_done_q <= 1'b0;
			strap_wait_q <= 3'h0;
		end else if (i_clk_en && !strap_done_q) begin
			if (strap_wait_q == 3'h5) begin
				rs232_q <= lvl_q[0];
				strap_done_q <= 1'b1;
			end else begin
				strap_wait_q <= strap_wait_q + 3'h1;
			end
		end
	end
	assign o_rs232_mode = rs232_q;

	wire logic rx_line = rs232_q ? lvl_q[3] : lvl_q[4];

	function automatic logic [31:0] rate_of(input logic [2:0] sel);
		case (sel)
			3'h0: rate_of = 32'd1200;
			3'h1: rate_of = 32'd2400;
			3'h2: rate_of = 32'd4800;
			3'h3: rate_of = 32'd9600;
			3'h4: rate_of = 32'd19200;
			3'h5: rate_of = 32'd38400;
			3'h6: rate_of = 32'd57600;
			3'h7: rate_of = 32'd115200;
			default: rate_of = `SCL_DEFAULT_BAUD;
		endcase
	endfunction
	logic [31:0] bit_cyc_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n)
			bit_cyc_q <= CLK_HZ / `SCL_DEFAULT_BAUD;
		else if (i_clk_en)
			bit_cyc_q <= CLK_HZ / rate_of(i_line_rate_setting);
	end

	// internal module reset and split: falling edges
	logic rst_prev_q, split_prev_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rst_prev_q <= 1'b1;
			split_prev_q <= 1'b1;
		end else if (i_clk_en) begin
			rst_prev_q <= lvl_q[1];
			split_prev_q <= lvl_q[2];
		end
	end
	wire logic mrst_fall = rst_prev_q & ~lvl_q[1];
	wire logic split_fall = split_prev_q & ~lvl_q[2];
	// module reset held while pin low
	wire logic soft_rst = ~lvl_q[1];
	wire logic auto_mode = (i_operating_mode_setting == SCL_MODE_AUTO);

	// receiver, 8N1
	scl_rx_state_t rx_st_q;
	logic [31:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_done;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || soft_rst) begin
			rx_st_q <= SCL_RX_IDLE;
			rx_cnt_q <= 32'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h0;
		end else if (i_clk_en) begin
			case (rx_st_q)
				SCL_RX_IDLE: begin
					rx_cnt_q <= 32'h0;
					if (!rx_line && strap_done_q)
						rx_st_q <= SCL_RX_START;
				end
				SCL_RX_START: begin
					rx_cnt_q <= rx_cnt_q + 32'h1;
					if (rx_cnt_q == (bit_cyc_q >> 1)) begin
						rx_cnt_q <= 32'h0;
						rx_st_q <= rx_line ? SCL_RX_IDLE : SCL_RX_DATA;
						rx_bit_q <= 3'h0;
					end
				end
				SCL_RX_DATA: begin
					rx_cnt_q <= rx_cnt_q + 32'h1;
					if (rx_cnt_q == bit_cyc_q - 32'h1) begin
						rx_cnt_q <= 32'h0;
						rx_sh_q <= {rx_line, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7)
							rx_st_q <= SCL_RX_STOP;
					end
				end
				SCL_RX_STOP: begin
					rx_cnt_q <= rx_cnt_q + 32'h1;
					if (rx_cnt_q == bit_cyc_q - 32'h1)
						rx_st_q <= SCL_RX_IDLE;
				end
				default: rx_st_q <= SCL_RX_IDLE;
			endcase
		end
	end
	assign rx_done = i_clk_en && rx_st_q == SCL_RX_STOP && rx_cnt_q == bit_cyc_q - 32'h1
		&& rx_line;

	// output byte register; stop bit time covers storage latency
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || soft_rst) begin
			o_store_data <= 8'h0;
			o_store_valid <= 1'b0;
			o_overrun <= 1'b0;
		end else if (i_clk_en) begin
			if (rx_done) begin
				o_store_data <= rx_sh_q;
				o_store_valid <= 1'b1;
				if (o_store_valid && !i_store_ready)
					o_overrun <= 1'b1;
			end else if (i_store_ready) begin
				o_store_valid <= 1'b0;
			end
		end
	end
	wire logic byte_taken = i_clk_en & o_store_valid & i_store_ready;

	// commit on byte count or idle timeout
	logic [11:0] frame_cnt_q;
	logic [31:0] idle_cyc_q;
	logic [15:0] idle_ms_q;
	logic pending_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || soft_rst) begin
			frame_cnt_q <= 12'h0;
			idle_cyc_q <= 32'h0;
			idle_ms_q <= 16'h0;
			pending_q <= 1'b0;
			o_commit <= 1'b0;
		end else if (i_clk_en) begin
			o_commit <= 1'b0;
			if (byte_taken) begin
				idle_cyc_q <= 32'h0;
				idle_ms_q <= 16'h0;
				if (frame_cnt_q + 12'h1 >= i_flush_byte_count || frame_cnt_q == 12'hffe) begin
					frame_cnt_q <= 12'h0;
					pending_q <= 1'b0;
					o_commit <= 1'b1;
				end else begin
					frame_cnt_q <= frame_cnt_q + 12'h1;
					pending_q <= 1'b1;
				end
			end else if (pending_q) begin
				idle_cyc_q <= idle_cyc_q + 32'h1;
				if (idle_cyc_q == CYC_PER_MS - 1) begin
					idle_cyc_q <= 32'h0;
					idle_ms_q <= idle_ms_q + 16'h1;
				end
				if (idle_ms_q > i_idle_flush_ms) begin
					frame_cnt_q <= 12'h0;
					pending_q <= 1'b0;
					o_commit <= 1'b1;
				end
			end
		end
	end

	logic [31:0] file_len_q;
	wire logic size_split = auto_mode && i_file_max_len != 32'h0 && byte_taken &&
		file_len_q + 32'h1 >= i_file_max_len;
	// file index advance only in auto mode
	wire logic idx_step = auto_mode & i_clk_en & (split_fall | mrst_fall | size_split);
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_file_index <= '0;
			o_file_new <= 1'b0;
			file_len_q <= 32'h0;
		end else if (i_clk_en) begin
			o_file_new <= idx_step;
			if (idx_step) begin
				o_file_index <= o_file_index + 1'b1;
				file_len_q <= 32'h0;
			end else if (byte_taken) begin
				file_len_q <= file_len_q + 32'h1;
			end
		end
	end

	logic [31:0] hb_cnt_q;
	logic [7:0] hb_val_q;
	logic hb_go;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || soft_rst) begin
			hb_cnt_q <= 32'h0;
		end else if (i_clk_en) begin
			hb_cnt_q <= (hb_cnt_q == HEARTBEAT_CYC - 1) ? 32'h0 : hb_cnt_q + 32'h1;
		end
	end
	assign hb_go = i_clk_en && hb_cnt_q == HEARTBEAT_CYC - 1;

	// transmitter, 8N1
	scl_tx_state_t tx_st_q;
	logic [31:0] tx_cnt_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic tx_line_q;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || soft_rst) begin
			tx_st_q <= SCL_TX_IDLE;
			tx_cnt_q <= 32'h0;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h0;
			tx_line_q <= 1'b1;
			hb_val_q <= 8'h0;
		end else if (i_clk_en) begin
			tx_cnt_q <= tx_cnt_q + 32'h1;
			case (tx_st_q)
				SCL_TX_IDLE: begin
					tx_cnt_q <= 32'h0;
					tx_line_q <= 1'b1;
					if (hb_go) begin
						tx_sh_q <= hb_val_q;
						hb_val_q <= hb_val_q + 8'h1;
						tx_line_q <= 1'b0;
						tx_st_q <= SCL_TX_START;
					end
				end
				SCL_TX_START: begin
					if (tx_cnt_q == bit_cyc_q - 32'h1) begin
						tx_cnt_q <= 32'h0;
						tx_line_q <= tx_sh_q[0];
						tx_bit_q <= 3'h0;
						tx_st_q <= SCL_TX_DATA;
					end
				end
				// data lsb first then one stop bit
				SCL_TX_DATA: begin
					if (tx_cnt_q == bit_cyc_q - 32'h1) begin
						tx_cnt_q <= 32'h0;
						tx_bit_q <= tx_bit_q + 3'h1;
						if (tx_bit_q == 3'h7) begin
							tx_line_q <= 1'b1;
							tx_st_q <= SCL_TX_STOP;
						end else begin
							tx_line_q <= tx_sh_q[tx_bit_q + 3'h1];
						end
					end
				end
				SCL_TX_STOP: begin
					if (tx_cnt_q == bit_cyc_q - 32'h1)
						tx_st_q <= SCL_TX_IDLE;
				end
				default: tx_st_q <= SCL_TX_IDLE;
			endcase
		end
	end

	// heartbeat on the output matching the strap mode
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_tx_lvttl <= 1'b1;
			o_tx_rs232 <= 1'b1;
		end else if (i_clk_en) begin
			o_tx_lvttl <= rs232_q ? 1'b1 : tx_line_q;
			o_tx_rs232 <= rs232_q ? tx_line_q : 1'b1;
		end
	end
endmodule : scl_logger_io

// File: tb/scl_app_model.sv
// Purpose: application device driving the logger receive lines
// Assumes: bit period given in clock cycles
// Notes: the unused line carries the inverse frame, so it must be ignored
`timescale 1ns/10ps
module scl_app_model #(
	parameter int BIT_CYC = 1736
) (
	input wire logic i_clock,
	input wire logic i_use_rs232,
	output logic o_rx_lvttl,
	output logic o_rx_rs232
);
	logic line_q = 1'b1;
	assign o_rx_lvttl = i_use_rs232 ? ~line_q : line_q;
	assign o_rx_rs232 = i_use_rs232 ? line_q : ~line_q;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_q = f[i];
			repeat (BIT_CYC) @(negedge i_clock);
		end
	endtask : send
endmodule : scl_app_model

// File: tb/scl_logger_io_properties.sv
// Purpose: port checks for the logger front end
// Assumes: 115200 baud
// Notes: bound into the top module
`timescale 1ns/10ps
module scl_logger_io_properties #(
	parameter int unsigned IDX_W = 16
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_file_split_n,
	input wire logic i_module_reset_n,
	input wire scl_pkg::scl_mode_t i_operating_mode_setting,
	input wire logic o_tx_lvttl,
	input wire logic o_tx_rs232,
	input wire logic o_commit,
	input wire logic [IDX_W-1:0] o_file_index,
	input wire logic o_rs232_mode
);
	import scl_pkg::*;
	logic [15:0] low_q;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// length of a low run on the lvttl output
	always_ff @(posedge i_clock) begin
		low_q <= (!i_rst_n || o_tx_lvttl) ? 16'h0 : low_q + 16'h1;
	end
	a_commit_pulse: assert property (o_commit |=> !o_commit)
		else $error("commit too long");
	a_index_step: assert property (o_file_index != $past(o_file_index)
		|-> o_file_index == $past(o_file_index) + 1'b1) else $error("index jump");
	a_normal_hold: assert property (i_operating_mode_setting == SCL_MODE_NORMAL
		&& $past(i_operating_mode_setting) == SCL_MODE_NORMAL |-> $stable(o_file_index))
		else $error("index moved in normal mode");
	a_split_bump: assert property ($fell(i_file_split_n) && i_clk_en
		&& i_operating_mode_setting == SCL_MODE_AUTO |-> ##[1:8] (o_file_index
		== $past(o_file_index) + 1'b1)) else $error("split lost");
	a_pin_bump: assert property ($fell(i_module_reset_n)
		&& i_operating_mode_setting == SCL_MODE_AUTO |-> ##[1:8] o_file_index
		!= $past(o_file_index, 8)) else $error("pin reset did not bump");
	a_lvttl_quiet: assert property (o_rs232_mode |-> o_tx_lvttl)
		else $error("lvttl output active in rs232 mode");
	a_rs232_quiet: assert property (!o_rs232_mode |-> o_tx_rs232)
		else $error("rs232 output active in lvttl mode");
	a_frame_low: assert property (low_q <= 16'd15640)
		else $error("tx low longer than start and eight bits");
endmodule : scl_logger_io_properties
bind scl_logger_io scl_logger_io_properties #(.IDX_W(IDX_W)) i_props (.i_clock, .i_rst_n, .i_clk_en,
	.i_file_split_n, .i_module_reset_n, .i_operating_mode_setting, .o_tx_lvttl,
	.o_tx_rs232, .o_commit, .o_file_index, .o_rs232_mode);

// File: tb/scl_logger_io_tb.sv
// Purpose: self-checking bench for the logger front end
// Assumes: 115200 baud, heartbeat and ms counts shortened
// Notes: heartbeats are decoded while the model sends
`timescale 1ns/10ps
module scl_logger_io_tb;
	import scl_pkg::*;
	localparam int BIT = 1736;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic split_n = 1'b1;
	logic pin_rst_n = 1'b1;
	logic strap = 1'b1;
	logic use_rs232 = 1'b0;
	logic ready = 1'b1;
	logic clk_en = 1'b1;
	logic [15:0] idle_ms = 16'hffff;
	logic [31:0] max_len = 32'h0;
	logic overrun;
	scl_mode_t mode = SCL_MODE_NORMAL;
	logic rx_lvttl, rx_rs232, tx_lvttl, tx_rs232, valid, commit, fnew, rs_mode;
	logic [7:0] data;
	logic [15:0] idx;
	logic [7:0] q[$];
	int n_errors = 0;
	int check_count = 0;
	int n_commit = 0;
	int n_new = 0;
	initial forever #2.5 i_clock = ~i_clock;
	scl_logger_io #(.HEARTBEAT_CYC(20000), .CYC_PER_MS(20)) i_dut (.i_clock, .i_rst_n,
		.i_clk_en(clk_en), .i_rx_lvttl(rx_lvttl), .i_rx_rs232(rx_rs232),
		.i_file_split_n(split_n), .i_module_reset_n(pin_rst_n),
		.i_level_select_strap_a(strap), .i_level_select_strap_b(strap),
		.i_operating_mode_setting(mode), .i_line_rate_setting(3'h7),
		.i_flush_byte_count(12'h002), .i_idle_flush_ms(idle_ms), .i_file_max_len(max_len),
		.i_store_ready(ready), .o_tx_lvttl(tx_lvttl), .o_tx_rs232(tx_rs232),
		.o_store_data(data), .o_store_valid(valid), .o_commit(commit), .o_file_index(idx),
		.o_file_new(fnew), .o_rs232_mode(rs_mode), .o_overrun(overrun));
	scl_app_model #(.BIT_CYC(BIT)) i_model (.i_clock, .i_use_rs232(use_rs232),
		.o_rx_lvttl(rx_lvttl), .o_rx_rs232(rx_rs232));
	always @(posedge i_clock) begin
		if (valid === 1'b1 && ready) q.push_back(data);
		if (commit === 1'b1) n_commit++;
		if (fnew === 1'b1) n_new++;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic final_report();
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic do_reset(input logic s);
		i_rst_n = 1'b0;
		strap = s;
		use_rs232 = ~s;
		repeat (8) @(negedge i_clock);
		i_rst_n = 1'b1;
		repeat (8) @(negedge i_clock);
		q.delete();
		n_commit = 0;
	endtask : do_reset
	task automatic get_hb(input logic rs, output logic [7:0] v);
		int n;
		n = 0;
		while ((rs ? tx_rs232 : tx_lvttl) === 1'b1 && n < 30000) begin
			@(negedge i_clock);
			n++;
		end
		if (n >= 30000) begin
			n_errors++;
			final_report();
		end else begin
			repeat (BIT / 2) @(negedge i_clock);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(negedge i_clock);
				v[i] = rs ? tx_rs232 : tx_lvttl;
			end
			repeat (BIT) @(negedge i_clock);
			check("stop_bit", rs ? tx_rs232 : tx_lvttl, 1'b1);
		end
	endtask : get_hb
	task automatic pulse(input logic rst);
		// low for scaled 50 ms, line quiet
		if (rst) pin_rst_n = 1'b0;
		else split_n = 1'b0;
		repeat (1000) @(negedge i_clock);
		pin_rst_n = 1'b1;
		split_n = 1'b1;
		repeat (20) @(negedge i_clock);
	endtask : pulse
	task automatic t_lvttl();
		logic [7:0] h0, h1;
		do_reset(1'b1);
		fork
			begin
				i_model.send(8'h80);
				i_model.send(8'h01);
			end
			begin
				get_hb(1'b0, h0);
				get_hb(1'b0, h1);
			end
		join
		check("heartbeat0", h0, 8'h00);
		check("heartbeat1", h1, 8'h01);
		check("rs232_mode", rs_mode, 1'b0);
		check("byte_count", q.size(), 2);
		check("byte0", q[0], 8'h80);
		check("byte1", q[1], 8'h01);
		check("commits", n_commit, 1);
		check("overrun", overrun, 1'b0);
	endtask : t_lvttl
	task automatic t_rs232();
		logic [7:0] h0;
		do_reset(1'b0);
		fork
			i_model.send(8'h5a);
			get_hb(1'b1, h0);
		join
		check("rs232_mode", rs_mode, 1'b1);
		check("heartbeat", h0, 8'h00);
		check("byte_count", q.size(), 1);
		check("byte", q[0], 8'h5a);
		check("idx_reset", idx, 16'h0000);
	endtask : t_rs232
	task automatic t_split();
		n_new = 0;
		pulse(1'b0);
		check("idx_normal", idx, 16'h0000);
		mode = SCL_MODE_AUTO;
		pulse(1'b0);
		check("idx_split", idx, 16'h0001);
		pulse(1'b1);
		check("idx_pin_reset", idx, 16'h0002);
		check("new_pulses", n_new, 2);
		check("tx_idle", {tx_lvttl, tx_rs232}, 2'b11);
	endtask : t_split
	task automatic t_size();
		max_len = 32'h2;
		idle_ms = 16'h0;
		n_commit = 0;
		i_model.send(8'h11);
		i_model.send(8'h22);
		repeat (100) @(negedge i_clock);
		check("commits_idle", n_commit, 2);
		check("idx_size", idx, 16'h0003);
		check("last_byte", q[q.size() - 1], 8'h22);
		clk_en = 1'b0;
		pulse(1'b0);
		clk_en = 1'b1;
		repeat (20) @(negedge i_clock);
		check("idx_frozen", idx, 16'h0003);
	endtask : t_size
	initial begin
		t_lvttl();
		t_rs232();
		t_split();
		t_size();
		final_report();
	end
endmodule : scl_logger_io_tb
